// ==== rtl/tsi_status_irq.sv ====
// Status word, interrupt flags, interrupt enables and interrupt pin of the tag device.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module tsi_status_irq
   import tsi_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire logic [TSI_ADDR_W-1:0] reg_addr,
   input  wire logic [TSI_DATA_W-1:0] reg_wdata,
   input  wire logic                  reg_write,
   input  wire logic                  reg_read,
   output logic      [TSI_DATA_W-1:0] reg_rdata,
   input  wire logic                  cmd_valid,
   input  wire logic [1:0]            cmd_code,
   input  wire logic                  radio_activity_flag,
   input  wire logic                  crc_active,
   input  wire logic                  device_ready,
   input  wire logic                  read_prefetch_event,
   input  wire logic                  fatal_fault_event,
   input  wire logic                  field_loss_event,
   input  wire logic                  parity_check_fault_event,
   input  wire logic                  crc_done_event,
   output logic                       irq_pin_out,
   output logic                       irq_pin_oe_n,
   output logic                       irq_request
);

   // -------------------------------------------------------------------------
   // Input synchronisation
   // -------------------------------------------------------------------------
   logic [2:0] level_sync;

   tsi_sync #(.W(3)) u_level_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .async_in ({radio_activity_flag, crc_active, device_ready}),
      .sync_out (level_sync)
   );

   logic radio_s;
   logic crc_s;
   logic ready_s;
   assign radio_s = level_sync[2];
   assign crc_s   = level_sync[1];
   assign ready_s = level_sync[0];

   // -------------------------------------------------------------------------
   // Register write decode
   // -------------------------------------------------------------------------
   logic wr_flag;
   logic wr_enable;
   logic wr_control;
   assign wr_flag    = reg_write && (reg_addr == TSI_OFF_FLAG);
   assign wr_enable  = reg_write && (reg_addr == TSI_OFF_ENABLE);
   assign wr_control = reg_write && (reg_addr == TSI_OFF_CONTROL);

   // -------------------------------------------------------------------------
   // Pending command field
   // -------------------------------------------------------------------------
   tsi_cmd_e cmd_field;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cmd_field <= TSI_CMD_NONE;
      end else if (cmd_valid) begin
         cmd_field <= tsi_cmd_e'(cmd_code);
      end
   end

   // -------------------------------------------------------------------------
   // Status word, read only
   // -------------------------------------------------------------------------
   logic [15:0] device_state_word;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         device_state_word <= TSI_RESET_VALUE;
      end else begin
         // Built only from internal sources, so a host write has no path here.
         device_state_word                          <= TSI_RESET_VALUE;
         device_state_word[TSI_ST_CMD_HI:TSI_ST_CMD_LO] <= cmd_field;
         device_state_word[TSI_ST_RADIO]            <= radio_s;
         device_state_word[TSI_ST_CRC]              <= crc_s;
         device_state_word[TSI_ST_READY]            <= ready_s;
      end
   end

   // -------------------------------------------------------------------------
   // Interrupt flags
   // -------------------------------------------------------------------------
   logic [15:0] event_vec;
   logic [15:0] irq_flag;
   logic [15:0] next_irq_flag;

   always_comb begin
      event_vec               = TSI_RESET_VALUE;
      event_vec[TSI_EV_HI]     = read_prefetch_event;
      event_vec[TSI_EV_HI-1]   = fatal_fault_event;
      event_vec[TSI_EV_HI-2]   = field_loss_event;
      event_vec[TSI_EV_HI-3]   = cmd_valid;
      event_vec[TSI_EV_HI-4]   = parity_check_fault_event;
      event_vec[TSI_EV_LO]     = crc_done_event;
   end

   always_comb begin
      next_irq_flag = irq_flag;
      if (wr_flag) begin
         next_irq_flag = irq_flag & ~reg_wdata;
      end
      // A new event wins over a clear in the same cycle.
      next_irq_flag = (next_irq_flag | event_vec) & TSI_EVENT_MASK;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_flag <= TSI_RESET_VALUE;
      end else begin
         irq_flag <= next_irq_flag;
      end
   end

   // -------------------------------------------------------------------------
   // Interrupt enables and control
   // -------------------------------------------------------------------------
   logic [15:0] irq_enable_mask;
   logic [15:0] irq_control;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_enable_mask <= TSI_RESET_VALUE;
      end else if (wr_enable) begin
         irq_enable_mask <= reg_wdata & TSI_EVENT_MASK;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_control <= TSI_RESET_VALUE;
      end else if (wr_control) begin
         irq_control <= reg_wdata & TSI_CTL_MASK;
      end
   end

   // -------------------------------------------------------------------------
   // Interrupt pin
   // -------------------------------------------------------------------------
   logic next_request;
   assign next_request = |(next_irq_flag & irq_enable_mask);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_request  <= 1'b0;
         irq_pin_out  <= 1'b0;
         irq_pin_oe_n <= 1'b1;
      end else begin
         irq_request  <= next_request;
         irq_pin_out  <= irq_control[TSI_CTL_POL] ? next_request : ~next_request;
         irq_pin_oe_n <= ~irq_control[TSI_CTL_OUT_EN];
      end
   end

   // -------------------------------------------------------------------------
   // Register read port
   // -------------------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= TSI_RESET_VALUE;
      end else if (reg_read) begin
         case (reg_addr)
            TSI_OFF_FLAG:    reg_rdata <= irq_flag;
            TSI_OFF_ENABLE:  reg_rdata <= irq_enable_mask;
            TSI_OFF_STATUS:  reg_rdata <= device_state_word;
            TSI_OFF_CONTROL: reg_rdata <= irq_control;
            default:         reg_rdata <= TSI_RESET_VALUE;
         endcase
      end else begin
         reg_rdata <= TSI_RESET_VALUE;
      end
   end

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   sequence s_enabled_event;
      crc_done_event && irq_enable_mask[TSI_EV_LO];
   endsequence

   sequence s_request_up;
      ##1 irq_request;
   endsequence

   AST_CMD_LOAD: assert property (@(posedge core_clk) disable iff (rst)
      cmd_valid |=> ##1 (device_state_word[TSI_ST_CMD_HI:TSI_ST_CMD_LO] == $past(cmd_code, 2)))
      else $error("command field not loaded");

   AST_RADIO_BIT: assert property (@(posedge core_clk) disable iff (rst)
      device_state_word[TSI_ST_RADIO] == $past(radio_s))
      else $error("radio bit does not follow activity");

   AST_CRC_BIT: assert property (@(posedge core_clk) disable iff (rst)
      device_state_word[TSI_ST_CRC] == $past(crc_s))
      else $error("checksum bit does not follow engine");

   AST_RESERVED_ZERO: assert property (@(posedge core_clk) disable iff (rst)
      ((device_state_word & 16'hFFC8) == 16'h0000) && ((irq_enable_mask & ~TSI_EVENT_MASK) == 16'h0000))
      else $error("reserved bits not zero");

   AST_ENABLED_FIRES: assert property (@(posedge core_clk) disable iff (rst)
      s_enabled_event |-> s_request_up)
      else $error("enabled event did not raise request");

   AST_OR_COMBINE: assert property (@(posedge core_clk) disable iff (rst)
      ##1 (irq_request == |($past(next_irq_flag) & $past(irq_enable_mask))))
      else $error("request is not the OR of enabled flags");

   AST_MASKED_QUIET: assert property (@(posedge core_clk) disable iff (rst)
      (irq_enable_mask == 16'h0000) && $stable(irq_enable_mask) |=> !irq_request)
      else $error("request with all enables clear");

   AST_CLEAR_FLAG: assert property (@(posedge core_clk) disable iff (rst)
      wr_flag && reg_wdata[TSI_EV_LO] && !crc_done_event |=> !irq_flag[TSI_EV_LO])
      else $error("flag not cleared by write of one");

   AST_SET_WINS: assert property (@(posedge core_clk) disable iff (rst)
      crc_done_event |=> irq_flag[TSI_EV_LO])
      else $error("event lost");

   AST_PIN_HIZ: assert property (@(posedge core_clk) disable iff (rst)
      !irq_control[TSI_CTL_OUT_EN] |=> irq_pin_oe_n)
      else $error("pin driven while output disabled");

   // The pin leaves reset at zero whatever the polarity, so the first edge is skipped.
   AST_POLARITY: assert property (@(posedge core_clk) disable iff (rst)
      !$past(rst) |-> (irq_pin_out == (irq_request ^ ~$past(irq_control[TSI_CTL_POL]))))
      else $error("pin polarity wrong");

   // -------------------------------------------------------------------------
   // Further assertions on status, enables, flags, control, pin and read port
   // -------------------------------------------------------------------------
   sequence s_full_clear;
      wr_flag && (reg_wdata == TSI_EVENT_MASK) && (event_vec == TSI_RESET_VALUE);
   endsequence

   AST_READY_BIT: assert property (@(posedge core_clk) disable iff (rst)
      device_state_word[TSI_ST_READY] == $past(ready_s))
      else $error("ready bit does not follow readiness");

   AST_CMD_HOLD: assert property (@(posedge core_clk) disable iff (rst)
      !cmd_valid |=> $stable(cmd_field))
      else $error("command field changed without a command");

   AST_FLAG_RESERVED: assert property (@(posedge core_clk) disable iff (rst)
      (irq_flag & ~TSI_EVENT_MASK) == TSI_RESET_VALUE)
      else $error("reserved flag bits not zero");

   AST_CTL_RESERVED: assert property (@(posedge core_clk) disable iff (rst)
      (irq_control & ~TSI_CTL_MASK) == TSI_RESET_VALUE)
      else $error("reserved control bits not zero");

   AST_PIN_DRIVEN: assert property (@(posedge core_clk) disable iff (rst)
      irq_control[TSI_CTL_OUT_EN] |=> !irq_pin_oe_n)
      else $error("pin not driven while output enabled");

   AST_PREFETCH_GATE: assert property (@(posedge core_clk) disable iff (rst)
      read_prefetch_event && irq_enable_mask[TSI_EV_HI] |=> irq_request)
      else $error("enabled prefetch event did not raise request");

   AST_FATAL_GATE: assert property (@(posedge core_clk) disable iff (rst)
      fatal_fault_event && irq_enable_mask[TSI_EV_HI-1] |=> irq_request)
      else $error("enabled fatal fault did not raise request");

   AST_FIELD_GATE: assert property (@(posedge core_clk) disable iff (rst)
      field_loss_event && irq_enable_mask[TSI_EV_HI-2] |=> irq_request)
      else $error("enabled field loss did not raise request");

   AST_SERVICE_GATE: assert property (@(posedge core_clk) disable iff (rst)
      cmd_valid && irq_enable_mask[TSI_EV_HI-3] |=> irq_request)
      else $error("enabled service request did not raise request");

   AST_PARITY_GATE: assert property (@(posedge core_clk) disable iff (rst)
      parity_check_fault_event && irq_enable_mask[TSI_EV_HI-4] |=> irq_request)
      else $error("enabled parity fault did not raise request");

   AST_NOTHING_ENABLED: assert property (@(posedge core_clk) disable iff (rst)
      ((irq_flag | event_vec) & irq_enable_mask) == TSI_RESET_VALUE |=> !irq_request)
      else $error("request without an enabled pending event");

   AST_ENABLE_WRITE: assert property (@(posedge core_clk) disable iff (rst)
      wr_enable |=> (irq_enable_mask == ($past(reg_wdata) & TSI_EVENT_MASK)))
      else $error("enable word not written");

   AST_ENABLE_HOLD: assert property (@(posedge core_clk) disable iff (rst)
      !wr_enable |=> $stable(irq_enable_mask))
      else $error("enable word changed without a write");

   AST_FLAG_KEEP: assert property (@(posedge core_clk) disable iff (rst)
      wr_flag && !reg_wdata[TSI_EV_HI] && irq_flag[TSI_EV_HI] |=> irq_flag[TSI_EV_HI])
      else $error("flag lost on write of zero");

   AST_FULL_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
      s_full_clear |=> !irq_request)
      else $error("request stays after all flags cleared");

   AST_READ_STATUS: assert property (@(posedge core_clk) disable iff (rst)
      reg_read && (reg_addr == TSI_OFF_STATUS) |=> reg_rdata == $past(device_state_word))
      else $error("status read data wrong");

   AST_READ_FLAG: assert property (@(posedge core_clk) disable iff (rst)
      reg_read && (reg_addr == TSI_OFF_FLAG) |=> reg_rdata == $past(irq_flag))
      else $error("flag read data wrong");

   AST_READ_ENABLE: assert property (@(posedge core_clk) disable iff (rst)
      reg_read && (reg_addr == TSI_OFF_ENABLE) |=> reg_rdata == $past(irq_enable_mask))
      else $error("enable read data wrong");

   AST_READ_IDLE: assert property (@(posedge core_clk) disable iff (rst)
      !reg_read |=> reg_rdata == TSI_RESET_VALUE)
      else $error("read data not zero outside a read");

   AST_READ_UNMAPPED: assert property (@(posedge core_clk) disable iff (rst)
      reg_read && (reg_addr != TSI_OFF_FLAG) && (reg_addr != TSI_OFF_ENABLE)
         && (reg_addr != TSI_OFF_STATUS) && (reg_addr != TSI_OFF_CONTROL)
         |=> reg_rdata == TSI_RESET_VALUE)
      else $error("unmapped read not zero");

endmodule
`default_nettype wire

// ==== pkg/tsi_pkg.sv ====
// Package with register map, field layout and status encodings of the tag status block.
package tsi_pkg;

   // -------------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------------
   localparam int          TSI_ADDR_W       = 16;
   localparam int          TSI_DATA_W       = 16;
   localparam logic [15:0] TSI_OFF_FLAG     = 16'hFFF8;
   localparam logic [15:0] TSI_OFF_ENABLE   = 16'hFFFA;
   localparam logic [15:0] TSI_OFF_STATUS   = 16'hFFFC;
   localparam logic [15:0] TSI_OFF_CONTROL  = 16'hFFFE;
   localparam logic [15:0] TSI_RESET_VALUE  = 16'h0000;

   // -------------------------------------------------------------------------
   // Field layout
   // -------------------------------------------------------------------------
   localparam int          TSI_ST_READY     = 0;
   localparam int          TSI_ST_CRC       = 1;
   localparam int          TSI_ST_RADIO     = 2;
   localparam int          TSI_ST_CMD_LO    = 4;
   localparam int          TSI_ST_CMD_HI    = 5;
   localparam int          TSI_EV_LO        = 3;
   localparam int          TSI_EV_HI        = 8;
   localparam int          TSI_EV_N         = 6;
   localparam logic [15:0] TSI_EVENT_MASK   = 16'h01F8;
   localparam int          TSI_CTL_POL      = 1;
   localparam int          TSI_CTL_OUT_EN   = 2;
   localparam logic [15:0] TSI_CTL_MASK     = 16'h0006;

   // -------------------------------------------------------------------------
   // Pending tag command codes
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      TSI_CMD_NONE   = 2'b00,
      TSI_CMD_SELECT = 2'b01,
      TSI_CMD_READ   = 2'b10,
      TSI_CMD_UPDATE = 2'b11
   } tsi_cmd_e;

endpackage

// ==== rtl/tsi_sync.sv ====
// Two flip-flop synchroniser for level inputs from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module tsi_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] stage1;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule
`default_nettype wire

// ==== test/tsi_host_model.sv ====
// Host controller model that drives the register port of the tag status block.
`timescale 1ns/100ps
`default_nettype none
module tsi_host_model
   import tsi_pkg::*;
(
   input  wire logic        core_clk,
   output logic      [15:0] reg_addr,
   output logic      [15:0] reg_wdata,
   output logic             reg_write,
   output logic             reg_read,
   input  wire logic [15:0] reg_rdata
);
   initial begin
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end

   // Released lines show the inverse so that stale values are never trusted.
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata;
   endtask

   // Polls the status word until the device reports ready, giving up after 20 reads.
   task automatic wait_ready(output logic ok);
      logic [15:0] d;
      ok = 1'b0;
      for (int i = 0; i < 20 && ok !== 1'b1; i++) begin
         rd(TSI_OFF_STATUS, d);
         ok = d[TSI_ST_READY];
      end
   endtask
endmodule
`default_nettype wire

// ==== test/tsi_status_irq_bench.sv ====
// Self-checking bench of the tag status and interrupt enable block.
`timescale 1ns/100ps
`default_nettype none
module tsi_status_irq_bench;
   import tsi_pkg::*;

   typedef struct {logic [15:0] en; logic [5:0] ev; logic req;} tsi_row_s;

   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, d;
   logic        reg_write, reg_read, irq_pin_out, irq_pin_oe_n, irq_request, ok;
   logic [5:0]  ev = 6'h00;
   logic [2:0]  lv = 3'h0;
   logic [1:0]  cmd_code = 2'h0;
   int          n_fail = 0;
   int          cmp_count = 0;
   tsi_row_s    rows [8] = '{
      '{16'h0008, 6'h01, 1'b1}, '{16'h0010, 6'h02, 1'b1}, '{16'h0020, 6'h04, 1'b1},
      '{16'h0040, 6'h08, 1'b1}, '{16'h0080, 6'h10, 1'b1}, '{16'h0100, 6'h20, 1'b1},
      '{16'h0000, 6'h3F, 1'b0}, '{16'h01F0, 6'h01, 1'b0}};

   always #25 core_clk = ~core_clk;

   tsi_host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));

   tsi_status_irq uut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .cmd_valid(ev[2]), .cmd_code(cmd_code),
      .radio_activity_flag(lv[2]), .crc_active(lv[1]), .device_ready(lv[0]),
      .read_prefetch_event(ev[5]), .fatal_fault_event(ev[4]), .field_loss_event(ev[3]),
      .parity_check_fault_event(ev[1]), .crc_done_event(ev[0]),
      .irq_pin_out(irq_pin_out), .irq_pin_oe_n(irq_pin_oe_n), .irq_request(irq_request));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic pulse(input logic [5:0] v);
      @(posedge core_clk);
      ev <= v;
      @(posedge core_clk);
      ev <= 6'h00;
      repeat (2) @(posedge core_clk);
      #1;
   endtask

   task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
      host.rd(a, d);
      chk(d, exp);
   endtask

   task automatic print_verdict;
      $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #200000;
      n_fail++;
      print_verdict();
   end

   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      #1;
      chk({14'h0, irq_request, irq_pin_oe_n}, 16'h0001);
      rdchk(TSI_OFF_ENABLE, 16'h0000);
      rdchk(TSI_OFF_STATUS, 16'h0000);
      rdchk(TSI_OFF_FLAG, 16'h0000);
      foreach (rows[i]) begin
         host.wr(TSI_OFF_ENABLE, rows[i].en);
         pulse(rows[i].ev);
         chk({15'h0, irq_request}, {15'h0, rows[i].req});
         rdchk(TSI_OFF_FLAG, {7'h0, rows[i].ev, 3'h0});
         host.wr(TSI_OFF_FLAG, 16'h0000);
         rdchk(TSI_OFF_FLAG, {7'h0, rows[i].ev, 3'h0});
         host.wr(TSI_OFF_FLAG, {7'h0, rows[i].ev, 3'h0});
         rdchk(TSI_OFF_FLAG, 16'h0000);
         chk({15'h0, irq_request}, 16'h0000);
      end
      host.wr(TSI_OFF_ENABLE, 16'h01F8);
      rdchk(TSI_OFF_ENABLE, 16'h01F8);
      rdchk(16'h0F00, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         @(posedge core_clk);
         lv <= 3'(1 << i);
         repeat (4) @(posedge core_clk);
         rdchk(TSI_OFF_STATUS, 16'(1 << i));
         host.wr(TSI_OFF_STATUS, 16'h0037);
         rdchk(TSI_OFF_STATUS, 16'(1 << i));
      end
      @(posedge core_clk);
      lv <= 3'h1;
      host.wait_ready(ok);
      chk({15'h0, ok}, 16'h0001);
      host.wr(TSI_OFF_ENABLE, 16'h0020);
      host.wr(TSI_OFF_CONTROL, 16'h0004);
      for (int c = 1; c < 5; c++) begin
         @(posedge core_clk);
         cmd_code <= 2'(c);
         pulse(6'h04);
         chk({15'h0, irq_request}, 16'h0001);
         chk({14'h0, irq_pin_out, irq_pin_oe_n}, 16'h0000);
         rdchk(TSI_OFF_STATUS, {10'h0, 2'(c), 4'h1});
         host.wr(TSI_OFF_FLAG, 16'h0020);
         repeat (2) @(posedge core_clk);
         #1 chk({14'h0, irq_pin_out, irq_request}, 16'h0002);
      end
      host.wr(TSI_OFF_CONTROL, 16'h0006);
      rdchk(TSI_OFF_CONTROL, 16'h0006);
      pulse(6'h04);
      chk({14'h0, irq_pin_out, irq_pin_oe_n}, 16'h0002);
      host.wr(TSI_OFF_CONTROL, 16'h0002);
      repeat (2) @(posedge core_clk);
      #1 chk({15'h0, irq_pin_oe_n}, 16'h0001);
      @(posedge core_clk);
      rst <= 1'b1;
      #1 chk({15'h0, irq_request}, 16'h0000);
      @(posedge core_clk);
      rst <= 1'b0;
      rdchk(TSI_OFF_FLAG, 16'h0000);
      rdchk(TSI_OFF_ENABLE, 16'h0000);
      rdchk(TSI_OFF_CONTROL, 16'h0000);
      print_verdict();
   end
endmodule
`default_nettype wire
